// File: logic/omc_pkg.sv
// Constants, register map and mode encodings of the operating mode controller.
// Assumes one system clock and a core that writes registers over a plain strobe port.
// Behaviour
// RULE1: after reset, run fast or slow as the startup clock option says
// RULE2: fast run uses fast oscillator, slow oscillator keeps running
// RULE3: high_clock_select 0 moves to slow run, 1 back to fast run
// RULE4: slow run leaves fast oscillator on; high_osc_stop 1 turns it off
// RULE5: software switches to slow run before stopping fast oscillator, never together
// RULE6: power_mode_field written 10b enters standby
// RULE7: standby stops execution, slow oscillator runs, enabled timers keep counting
// RULE8: standby wakes on timer0, timer1, watchdog, port B change or external interrupt
// RULE9: after wake, resume fast or slow according to high_clock_select
// RULE10: halt entered by halt instruction or power_mode_field written 01b
// RULE11: halt entry clears powerdown_flag, sets timeout_flag, clears watchdog counter
// RULE12: halt stops execution, all peripherals, and both oscillators
// RULE13: halt wakes only on watchdog, port B change or external interrupt
// RULE14: halt wake waits 512 clocks with crystal option, else 16
// RULE15: standby wake applies no stabilisation delay
// RULE16: saved global_irq_enable selects branch to vector 0x008 after wake
// RULE17: one write may change high_osc_stop and enter halt together
// RULE18: software avoids changing run speed in the write entering standby or halt
// RULE19: fast run routes slow clock to timer0 when selected and option allows
// RULE20: high_clock_select 1 picks fast oscillator, 0 picks slow
// RULE21: after wake, power_mode_field returns to running value

package omc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int          ADDR_W         = 4;
  localparam int          DATA_W         = 8;
  localparam logic [3:0]  OFS_OSC_CTRL   = 4'h0;
  localparam logic [3:0]  OFS_STATUS     = 4'h1;
  localparam logic [3:0]  OFS_ENABLE     = 4'h2;

  // Oscillator control fields
  localparam int          BIT_HCS        = 0;
  localparam int          BIT_HOSC_STOP  = 1;
  localparam int          BIT_PMF_LO     = 2;
  localparam int          BIT_LCK_T0     = 4;
  // Status fields
  localparam int          BIT_PD_FLAG    = 3;
  localparam int          BIT_TO_FLAG    = 4;
  localparam int          BIT_MODE_LO    = 5;
  // Enable fields
  localparam int          BIT_T0_EN      = 0;
  localparam int          BIT_T1_EN      = 1;
  localparam int          BIT_GIE        = 2;

  // power_mode_field codes
  localparam logic [1:0]  PMF_RUN        = 2'h0;
  localparam logic [1:0]  PMF_HALT       = 2'h1;
  localparam logic [1:0]  PMF_STANDBY    = 2'h2;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic        RST_HCS        = 1'b1;
  localparam logic        RST_HOSC_STOP  = 1'b0;
  localparam logic        RST_LCK_T0     = 1'b0;
  localparam logic        RST_PD_FLAG    = 1'b1;
  localparam logic        RST_TO_FLAG    = 1'b1;
  localparam logic        RST_T_EN       = 1'b0;
  localparam logic        RST_GIE        = 1'b0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int          WAKE_CNT_W     = 10;
  localparam int          WAKE_XTAL_CYC  = 512;
  localparam int          WAKE_RC_CYC    = 16;
  localparam logic [11:0] IRQ_VECTOR     = 12'h008;

  typedef enum logic [2:0] {
    OMC_BOOT      = 3'b000,
    OMC_RUN_FAST  = 3'b001,
    OMC_RUN_SLOW  = 3'b010,
    OMC_STANDBY   = 3'b011,
    OMC_HALT      = 3'b100,
    OMC_HALT_WAKE = 3'b101
  } omc_mode_t;

endpackage

// File: logic/omc_wake_if.sv
// Handshake between the mode sequencer and its halt wake-up delay timer.
// Assumes both ends run on the same system clock.
`timescale 1ns/10ps

interface omc_wake_if;
  logic start;
  logic long_sel;
  logic done;

  modport ctrl  (output start, output long_sel, input done);
  modport timer (input start, input long_sel, output done);
endinterface

// File: logic/omc_wake_timer.sv
// Halt wake-up stabilisation counter.
// Assumes start is a one-cycle pulse in the first cycle of the wake wait; done then
// rises in the last cycle of a wait that lasts exactly the selected count.
`timescale 1ns/10ps

module omc_wake_timer #(
  parameter int LONG_CYC  = omc_pkg::WAKE_XTAL_CYC,
  parameter int SHORT_CYC = omc_pkg::WAKE_RC_CYC
) (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  omc_wake_if.timer wk
);

  localparam int CW = omc_pkg::WAKE_CNT_W;

  logic [CW-1:0] cnt_reg;
  logic          busy_reg;
  logic          done_reg;

  // ----------------------------------------------------------------
  // Countdown
  // ----------------------------------------------------------------
  // Loads count minus two: the start cycle itself is the first waited cycle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg  <= '0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      done_reg <= busy_reg && (cnt_reg == CW'(1));
      if (wk.start) begin
        cnt_reg  <= wk.long_sel ? CW'(LONG_CYC - 2) : CW'(SHORT_CYC - 2);
        busy_reg <= 1'b1;
      end else if (busy_reg) begin
        cnt_reg  <= cnt_reg - CW'(1);
        if (cnt_reg == CW'(1)) begin
          busy_reg <= 1'b0;
        end
      end
    end
  end

  assign wk.done = done_reg;

endmodule

// File: logic/omc_mode_ctrl.sv
// Operating mode controller: run speed, standby, halt, wake-up and oscillator gating.
// Assumes core, interrupt sources and option straps all sit on clk_sys; straps hold
// steady from reset onward.
`timescale 1ns/10ps

module omc_mode_ctrl (
  input  wire logic                       clk_sys,
  input  wire logic                       resetn,
  // register port
  input  wire logic [omc_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [omc_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  output logic      [omc_pkg::DATA_W-1:0] reg_rdata,
  // core
  input  wire logic                       halt_instr,
  input  wire logic                       irq_on_instruction,
  input  wire logic                       irq_off_instruction,
  // wake sources
  input  wire logic                       timer0_overflow,
  input  wire logic                       timer1_underflow,
  input  wire logic                       watchdog_timeout,
  input  wire logic                       portb_change,
  input  wire logic                       ext_irq,
  // option straps
  input  wire logic                       opt_startup_fast,
  input  wire logic                       fast_crystal_option,
  input  wire logic                       mid_crystal_option,
  input  wire logic                       slow_crystal_option,
  input  wire logic                       opt_timer0_slow_src,
  // clock and gating
  output logic                            sys_clk_sel_fast,
  output logic                            fast_osc_en,
  output logic                            slow_osc_en,
  output logic                            cpu_run,
  output logic                            periph_en,
  output logic                            timer0_run,
  output logic                            timer1_run,
  output logic                            timer0_slow_clk,
  output logic                            watchdog_clear,
  output logic                            wake_branch,
  output logic      [11:0]                wake_vector
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta_reg;
  logic rst_n;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rst_meta_reg <= 1'b0;
      rst_n        <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n        <= rst_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  omc_pkg::omc_mode_t mode_reg;
  omc_pkg::omc_mode_t mode_next;

  logic       hcs_reg;
  logic       hosc_stop_reg;
  logic [1:0] pmf_reg;
  logic       lck_t0_reg;
  logic       t0_en_reg;
  logic       t1_en_reg;
  logic       gie_reg;
  logic       gie_saved_reg;
  logic       pd_flag_reg;
  logic       to_flag_reg;
  logic       xtal_opt_reg;
  logic       t0_src_opt_reg;

  logic       wr_osc;
  logic       wr_en;
  logic       running;
  logic       wake_any;
  logic       wake_halt;
  logic       enter_halt;
  logic       leave_sleep;
  logic       resume_fast;

  omc_wake_if wk ();

  function automatic logic is_addr(input logic [omc_pkg::ADDR_W-1:0] a,
                                   input logic [3:0]                 ofs);
    is_addr = (a == ofs);
  endfunction

  assign wr_osc  = reg_wr && is_addr(reg_addr, omc_pkg::OFS_OSC_CTRL);
  assign wr_en   = reg_wr && is_addr(reg_addr, omc_pkg::OFS_ENABLE);
  assign running = (mode_reg == omc_pkg::OMC_RUN_FAST) ||
                   (mode_reg == omc_pkg::OMC_RUN_SLOW);

  assign wake_halt = watchdog_timeout || portb_change || ext_irq;            // RULE13
  assign wake_any  = wake_halt || timer0_overflow || timer1_underflow;       // RULE8

  assign enter_halt  = running && (halt_instr || pmf_reg == omc_pkg::PMF_HALT); // RULE10
  assign leave_sleep = ((mode_reg == omc_pkg::OMC_STANDBY) && wake_any) ||
                       ((mode_reg == omc_pkg::OMC_HALT_WAKE) && wk.done);
  assign resume_fast = hcs_reg;                                              // RULE9

  // ----------------------------------------------------------------
  // Mode sequencer
  // ----------------------------------------------------------------
  always_comb begin
    mode_next = mode_reg;
    case (mode_reg)
      omc_pkg::OMC_BOOT: begin
        mode_next = opt_startup_fast ? omc_pkg::OMC_RUN_FAST : omc_pkg::OMC_RUN_SLOW; // RULE1
      end
      omc_pkg::OMC_RUN_FAST, omc_pkg::OMC_RUN_SLOW: begin
        if (enter_halt) begin
          mode_next = omc_pkg::OMC_HALT;
        end else if (pmf_reg == omc_pkg::PMF_STANDBY) begin
          mode_next = omc_pkg::OMC_STANDBY;                                  // RULE6
        end else begin
          mode_next = hcs_reg ? omc_pkg::OMC_RUN_FAST : omc_pkg::OMC_RUN_SLOW; // RULE3 RULE20
        end
      end
      omc_pkg::OMC_STANDBY: begin
        // No stabilisation wait: the slow oscillator never stopped
        if (wake_any) begin
          mode_next = resume_fast ? omc_pkg::OMC_RUN_FAST : omc_pkg::OMC_RUN_SLOW; // RULE15
        end
      end
      omc_pkg::OMC_HALT: begin
        if (wake_halt) begin
          mode_next = omc_pkg::OMC_HALT_WAKE;
        end
      end
      omc_pkg::OMC_HALT_WAKE: begin
        if (wk.done) begin
          mode_next = resume_fast ? omc_pkg::OMC_RUN_FAST : omc_pkg::OMC_RUN_SLOW; // RULE14
        end
      end
      default: begin
        mode_next = omc_pkg::OMC_BOOT;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg <= omc_pkg::OMC_BOOT;
    end else begin
      mode_reg <= mode_next;
    end
  end

  // Straps caught once, in the boot cycle after reset release
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      xtal_opt_reg   <= 1'b0;
      t0_src_opt_reg <= 1'b0;
    end else if (mode_reg == omc_pkg::OMC_BOOT) begin
      xtal_opt_reg   <= fast_crystal_option || mid_crystal_option || slow_crystal_option;
      t0_src_opt_reg <= opt_timer0_slow_src;
    end
  end

  // ----------------------------------------------------------------
  // Oscillator control register
  // ----------------------------------------------------------------
  // Writes are only meaningful while the core runs; high_osc_stop may change in
  // the same write that requests halt.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      hcs_reg       <= omc_pkg::RST_HCS;
      hosc_stop_reg <= omc_pkg::RST_HOSC_STOP;
      lck_t0_reg    <= omc_pkg::RST_LCK_T0;
    end else if (mode_reg == omc_pkg::OMC_BOOT) begin
      hcs_reg       <= opt_startup_fast;                                     // RULE1
    end else if (wr_osc && running) begin
      hcs_reg       <= reg_wdata[omc_pkg::BIT_HCS];                          // RULE3
      hosc_stop_reg <= reg_wdata[omc_pkg::BIT_HOSC_STOP];                    // RULE4 RULE17
      lck_t0_reg    <= reg_wdata[omc_pkg::BIT_LCK_T0];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pmf_reg <= omc_pkg::PMF_RUN;
    end else if (leave_sleep) begin
      pmf_reg <= omc_pkg::PMF_RUN;                                           // RULE21
    end else if (halt_instr && running) begin
      pmf_reg <= omc_pkg::PMF_HALT;
    end else if (wr_osc && running) begin
      pmf_reg <= reg_wdata[omc_pkg::BIT_PMF_LO +: 2];                        // RULE6 RULE10
    end
  end

  // ----------------------------------------------------------------
  // Enables and global interrupt enable
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      t0_en_reg <= omc_pkg::RST_T_EN;
      t1_en_reg <= omc_pkg::RST_T_EN;
    end else if (wr_en && running) begin
      t0_en_reg <= reg_wdata[omc_pkg::BIT_T0_EN];
      t1_en_reg <= reg_wdata[omc_pkg::BIT_T1_EN];
    end
  end

  // A vectored wake hands control to the service routine with interrupts off
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      gie_reg <= omc_pkg::RST_GIE;
    end else if (leave_sleep && gie_saved_reg) begin
      gie_reg <= 1'b0;
    end else if (irq_on_instruction) begin
      gie_reg <= 1'b1;
    end else if (irq_off_instruction) begin
      gie_reg <= 1'b0;
    end else if (wr_en && running) begin
      gie_reg <= reg_wdata[omc_pkg::BIT_GIE];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      gie_saved_reg <= 1'b0;
    end else if (running) begin
      gie_saved_reg <= gie_reg;                                              // RULE16
    end
  end

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pd_flag_reg <= omc_pkg::RST_PD_FLAG;
      to_flag_reg <= omc_pkg::RST_TO_FLAG;
    end else if (mode_next == omc_pkg::OMC_HALT && mode_reg != omc_pkg::OMC_HALT) begin
      pd_flag_reg <= 1'b0;                                                   // RULE11
      to_flag_reg <= 1'b1;                                                   // RULE11
    end
  end

  // ----------------------------------------------------------------
  // Halt wake-up delay
  // ----------------------------------------------------------------
  logic wake_start_reg;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wake_start_reg <= 1'b0;
    end else begin
      wake_start_reg <= (mode_reg == omc_pkg::OMC_HALT) && wake_halt;       // RULE14
    end
  end

  assign wk.start    = wake_start_reg;
  assign wk.long_sel = xtal_opt_reg;

  omc_wake_timer #(
    .LONG_CYC  (omc_pkg::WAKE_XTAL_CYC),
    .SHORT_CYC (omc_pkg::WAKE_RC_CYC)
  ) u_wake_timer (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .wk      (wk.timer)
  );

  // ----------------------------------------------------------------
  // Clock and gating outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sys_clk_sel_fast <= 1'b1;
      fast_osc_en      <= 1'b1;
      slow_osc_en      <= 1'b1;
      cpu_run          <= 1'b0;
      periph_en        <= 1'b0;
      timer0_run       <= 1'b0;
      timer1_run       <= 1'b0;
      timer0_slow_clk  <= 1'b0;
    end else begin
      sys_clk_sel_fast <= (mode_reg == omc_pkg::OMC_HALT_WAKE) ? hcs_reg :
                          (mode_reg == omc_pkg::OMC_RUN_FAST) ||
                          ((mode_reg == omc_pkg::OMC_STANDBY) && hcs_reg) ||
                          (mode_reg == omc_pkg::OMC_BOOT);                   // RULE20
      case (mode_reg)
        omc_pkg::OMC_RUN_FAST: fast_osc_en <= 1'b1;                          // RULE2
        omc_pkg::OMC_HALT:     fast_osc_en <= 1'b0;                          // RULE12
        default:               fast_osc_en <= !hosc_stop_reg || hcs_reg;     // RULE4
      endcase
      slow_osc_en      <= (mode_reg != omc_pkg::OMC_HALT);                   // RULE2 RULE7
      cpu_run          <= running;                                           // RULE7 RULE12
      periph_en        <= running;
      timer0_run       <= t0_en_reg && (running || mode_reg == omc_pkg::OMC_STANDBY); // RULE7
      timer1_run       <= t1_en_reg && (running || mode_reg == omc_pkg::OMC_STANDBY);
      timer0_slow_clk  <= (mode_reg == omc_pkg::OMC_RUN_FAST) && lck_t0_reg &&
                          t0_src_opt_reg;                                    // RULE19
    end
  end

  // Watchdog clear and wake branch pulses
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      watchdog_clear <= 1'b0;
      wake_branch    <= 1'b0;
      wake_vector    <= '0;
    end else begin
      watchdog_clear <= (mode_next == omc_pkg::OMC_HALT) &&
                        (mode_reg != omc_pkg::OMC_HALT);                     // RULE11
      wake_branch    <= leave_sleep && gie_saved_reg;                        // RULE16
      wake_vector    <= omc_pkg::IRQ_VECTOR;
    end
  end

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else if (!reg_rd) begin
      reg_rdata <= '0;
    end else if (is_addr(reg_addr, omc_pkg::OFS_OSC_CTRL)) begin
      reg_rdata <= {3'h0, lck_t0_reg, pmf_reg, hosc_stop_reg, hcs_reg};
    end else if (is_addr(reg_addr, omc_pkg::OFS_STATUS)) begin
      reg_rdata <= {mode_reg, to_flag_reg, pd_flag_reg, 3'h0};
    end else if (is_addr(reg_addr, omc_pkg::OFS_ENABLE)) begin
      reg_rdata <= {5'h00, gie_reg, t1_en_reg, t0_en_reg};
    end else begin
      reg_rdata <= '0;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [omc_pkg::WAKE_CNT_W-1:0] wake_len_reg;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wake_len_reg <= '0;
    end else if (mode_reg == omc_pkg::OMC_HALT_WAKE) begin
      wake_len_reg <= wake_len_reg + 10'h001;
    end else begin
      wake_len_reg <= '0;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_halt_req;
    running && halt_instr;
  endsequence

  sequence s_halt_entered;
    ##1 (mode_reg == omc_pkg::OMC_HALT) ##1 (!pd_flag_reg && to_flag_reg && !cpu_run);
  endsequence

  chk_boot_start: assert property ( // RULE1
    rst_n && mode_reg == omc_pkg::OMC_BOOT |=>
      (mode_reg == (opt_startup_fast ? omc_pkg::OMC_RUN_FAST : omc_pkg::OMC_RUN_SLOW)))
    else $error("boot mode does not follow startup option");

  chk_fast_clocks: assert property ( // RULE2
    mode_reg == omc_pkg::OMC_RUN_FAST |=> sys_clk_sel_fast && fast_osc_en && slow_osc_en)
    else $error("fast run clocks wrong");

  chk_slow_switch: assert property ( // RULE3
    wr_osc && running && !reg_wdata[omc_pkg::BIT_HCS] && reg_wdata[3:2] == 2'h0
      |=> ##1 mode_reg == omc_pkg::OMC_RUN_SLOW ##1 !sys_clk_sel_fast)
    else $error("slow switch missed");

  chk_hosc_stop: assert property ( // RULE4
    mode_reg == omc_pkg::OMC_RUN_SLOW && !hosc_stop_reg |=> fast_osc_en)
    else $error("fast oscillator stopped without request");

  chk_standby_entry: assert property ( // RULE6
    running && pmf_reg == omc_pkg::PMF_STANDBY && !halt_instr
      |=> mode_reg == omc_pkg::OMC_STANDBY)
    else $error("standby not entered");

  chk_standby_gating: assert property ( // RULE7
    mode_reg == omc_pkg::OMC_STANDBY |=> !cpu_run && slow_osc_en)
    else $error("standby gating wrong");

  chk_standby_wake: assert property ( // RULE8
    mode_reg == omc_pkg::OMC_STANDBY && (timer0_overflow || timer1_underflow)
      |=> running ##1 cpu_run)
    else $error("standby wake missed");

  chk_halt_entry: assert property (s_halt_req |-> s_halt_entered) // RULE11
    else $error("halt entry flags wrong");

  chk_halt_osc: assert property ( // RULE12
    mode_reg == omc_pkg::OMC_HALT |=> !fast_osc_en && !slow_osc_en && !timer0_run)
    else $error("halt leaves clocks running");

  chk_halt_timer: assert property ( // RULE13
    mode_reg == omc_pkg::OMC_HALT && !wake_halt |=> mode_reg == omc_pkg::OMC_HALT)
    else $error("halt left without valid source");

  chk_wake_delay: assert property ( // RULE14
    mode_reg == omc_pkg::OMC_HALT_WAKE && wk.done |->
      wake_len_reg == (xtal_opt_reg ? 10'h1FF : 10'h00F))
    else $error("halt wake delay wrong length");

  chk_wake_vector: assert property ( // RULE16
    leave_sleep |=> wake_branch == $past(gie_saved_reg))
    else $error("wake branch disagrees with saved enable");

  chk_mode_field: assert property ( // RULE21
    leave_sleep |=> pmf_reg == omc_pkg::PMF_RUN && running)
    else $error("mode field not restored after wake");

endmodule

// File: verification/omc_core_model.sv
// Partner model: core pulses and wake sources.
// Assumes one pulse at a time, launched just after a rising clk_sys edge.
`timescale 1ns/10ps

module omc_core_model (
  input  wire logic       clk_sys,
  output logic      [7:0] ev
);
  // Bits 0-4 wake sources, 5 halt, 6 irq on, 7 irq off
  initial ev = 8'h00;
  task automatic pulse(input int i);
    @(posedge clk_sys);
    ev[i] <= 1'b1;
    @(posedge clk_sys);
    ev    <= 8'h00;
  endtask
endmodule

// File: verification/omc_mode_ctrl_tb.sv
// Self-checking bench for the operating mode controller.
// Assumes straps change only under reset: first boot without crystal, second with.
`timescale 1ns/10ps

module omc_mode_ctrl_tb;
  logic        clk_sys   = 1'b0;
  logic        resetn    = 1'b0;
  logic [3:0]  reg_addr  = 4'h0;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic        opt_fast  = 1'b1;
  logic        xt        = 1'b0;
  logic        t0src     = 1'b1;
  logic [7:0]  reg_rdata, ev, d;
  logic        sf, fo, lo, run, pen, t0r, t1r, t0s, wdc, wbr, br;
  logic [11:0] vec;
  int          bad_count = 0;
  int          check_count = 0;
  int          cyc = 0;
  int          n;
  always #50 clk_sys = ~clk_sys;
  omc_core_model i_core (.clk_sys(clk_sys), .ev(ev));
  omc_mode_ctrl i_dut (.clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .halt_instr(ev[5]), .irq_on_instruction(ev[6]), .irq_off_instruction(ev[7]),
    .timer0_overflow(ev[0]), .timer1_underflow(ev[1]), .watchdog_timeout(ev[2]),
    .portb_change(ev[3]), .ext_irq(ev[4]), .opt_startup_fast(opt_fast),
    .fast_crystal_option(xt), .mid_crystal_option(xt), .slow_crystal_option(xt),
    .opt_timer0_slow_src(t0src), .sys_clk_sel_fast(sf), .fast_osc_en(fo), .slow_osc_en(lo),
    .cpu_run(run), .periph_en(pen), .timer0_run(t0r), .timer1_run(t1r),
    .timer0_slow_clk(t0s), .watchdog_clear(wdc), .wake_branch(wbr), .wake_vector(vec));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // Counts clocks until execution resumes, noting any vector branch
  task automatic wait_run;
    n  = 0;
    br = 1'b0;
    while (run !== 1'b1 && n < 600) begin
      @(posedge clk_sys);
      #1 n++;
      br |= wbr;
    end
  endtask
  task automatic close_out;
    $display("Checks %0d, mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      close_out();
    end
  end
  initial begin
    repeat (12) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (6) @(posedge clk_sys);
    rd(4'h1);
    check(d, 8'h38);
    check({sf, fo, lo}, 3'h7);
    rd(4'hF);
    check(d, 8'h00);
    wr(4'h0, 8'h10);
    check({sf, fo, t0s}, 3'h2);
    wr(4'h0, 8'h02);
    check(fo, 1'b0);
    wr(4'h0, 8'h11);
    check({sf, fo, t0s}, 3'h7);
    wr(4'h2, 8'h01);
    wr(4'h0, 8'h09);
    check({run, lo, t0r, t1r}, 4'h6);
    i_core.pulse(0);
    wait_run();
    check(n, 1);
    rd(4'h0);
    check(d, 8'h01);
    i_core.pulse(6);
    i_core.pulse(5);
    #1 check(wdc, 1'b1);
    repeat (2) @(posedge clk_sys);
    #1 check({fo, lo, run, pen, t0r}, 5'h00);
    i_core.pulse(1);
    repeat (4) @(posedge clk_sys);
    #1 check(run, 1'b0);
    i_core.pulse(3);
    wait_run();
    check(n, 17);
    check({br, vec}, 13'h1008);
    rd(4'h1);
    check(d, 8'h30);
    wr(4'h0, 8'h07);
    check(run, 1'b0);
    i_core.pulse(2);
    wait_run();
    check({br, sf}, 2'h1);
    // Second boot mid-run: slow start, crystal straps on, timer0 source off
    opt_fast <= 1'b0;
    xt       <= 1'b1;
    t0src    <= 1'b0;
    resetn   <= 1'b0;
    repeat (12) @(posedge clk_sys);
    resetn   <= 1'b1;
    repeat (6) @(posedge clk_sys);
    rd(4'h1);
    check(d, 8'h58);
    check({sf, fo}, 2'h1);
    wr(4'h0, 8'h11);
    check({sf, t0s}, 2'h2);
    wr(4'h0, 8'h05);
    i_core.pulse(4);
    wait_run();
    check(n, 513);
    close_out();
  end
endmodule
